// File: sweep_consts.svh
// offsets, field positions and reset values of the ramped sweep engine
`ifndef SWEEP_CONSTS_SVH
`define SWEEP_CONSTS_SVH

`define ADDR_W            6
`define OFF_LOW_WORD      6'h04
`define OFF_HIGH_WORD     6'h0a
`define OFF_STEP_WORD     6'h10
`define OFF_RAMP_RATE     6'h1a
`define OFF_CONTROL       6'h1f
`define OFF_STATUS        6'h20
`define WORD_BYTES        6'h06
`define RATE_BYTES        6'h03
`define ONE_BYTE          6'h01

`define CTRL_STEP_CLR_BIT 7
`define CTRL_FULL_CLR_BIT 6
`define CTRL_TRIANGLE_BIT 5
`define CTRL_MODE_MSB     3
`define CTRL_MODE_LSB     1

`define WORD_RESET        48'h0000_0000_0000
`define RATE_RESET        20'h0_0000
`define BYTE_ZERO         8'h00

`endif

// File: sweep_pkg.sv
// types shared by the ramped sweep engine files
package sweep_pkg;

    typedef enum logic [2:0]
    {
        MODE_SINGLE    = 3'b000,
        MODE_KEYING    = 3'b001,
        MODE_RAMPED    = 3'b010,
        MODE_CHIRP     = 3'b011,
        MODE_PHASE_KEY = 3'b100
    } mode_t;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_RAMP  = 2'b01,
        ST_DWELL = 2'b10
    } sweep_state_t;

    typedef struct packed
    {
        logic  stepClear;
        logic  fullClear;
        logic  triangle;
        mode_t mode;
    } ctrl_t;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] data;
    } reg_req_t;

endpackage

// File: ramp_rate_timer.sv
// countdown timer that paces the frequency steps
`timescale 1ns/10ps
module ramp_rate_timer #(
    parameter int RATE_W = 20
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              enable,
    input  wire logic              restart,
    input  wire logic [RATE_W-1:0] rate,
    output logic                   tick
);
    logic [RATE_W-1:0] cnt_q;
    logic [RATE_W-1:0] cnt_d;
    logic [RATE_W-1:0] loaded_q;
    logic [RATE_W-1:0] gap_q;
    logic              seen_q;

    // a new rate is picked up at each reload, so slope changes land on a step boundary
    assign tick  = enable && !restart && (cnt_q == '0);
    assign cnt_d = (!enable || restart || tick) ? rate : cnt_q - 1'b1;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    // helper for checking: rate actually loaded and cycles since the load
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded_q <= '0;
            gap_q    <= '0;
            seen_q   <= 1'b0;
        end
        else
        begin
            seen_q <= enable && !restart;
            if (!enable || restart || tick)
            begin
                loaded_q <= rate;
                gap_q    <= '0;
            end
            else
                gap_q <= gap_q + 1'b1;
        end
    end

    property p_tick_spacing;
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && seen_q) |-> (gap_q == loaded_q);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("ramp tick spacing is not rate plus one");

    property p_idle_silent;
        @(posedge sys_clk) disable iff (!rst_n)
        !enable |-> !tick;
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("ramp tick while timer disabled");

endmodule

// File: ramped_fsk_sweep_engine.sv
// ramped keying sweep engine: buffered registers, step accumulator, phase accumulator
// Operation
// - ramp rate timer is a 20-bit down-counter pulsing at zero.
// - a level change on the key input starts the ramp counter.
// - ramp pulses are spaced rate plus one system clocks apart.
// - at destination the counter stops and frequency holds while key stays.
// - each ramp pulse adds the 48-bit step word to the accumulator.
// - accumulator is added to low or subtracted from high, feeding phase.
// - early key toggle reverses the ramp at same rate and step.
// - triangle bit sweeps up and down continuously, key ignored.
// - triangle rise starts at high if key high, else at low.
// - new step and rate values are accepted at any time mid-ramp.
// - step clear gives a one-cycle accumulator clear; ramping resumes.
// - step clear held high re-clears on each update clock rising edge.
// - full clear holds both accumulators at zero while high.
// - ramped keying stays between tone words, chirp has no upper limit.
// - ramped sweep behaviour is active for mode code 010.
// - mode field in control register selects the five operating modes.
// - buffered values reach the core only on update clock rising edges.
`timescale 1ns/10ps
`include "sweep_consts.svh"
module ramped_fsk_sweep_engine #(
    parameter int WORD_W = 48,
    parameter int RATE_W = 20
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire sweep_pkg::reg_req_t regReq,
    output logic [7:0]               rdData,
    input  wire logic                updateClock,
    input  wire logic                keySelectInput,
    output logic [WORD_W-1:0]        tuningWord,
    output logic [WORD_W-1:0]        phaseWord,
    output logic                     sweeping,
    output logic                     atDestination
);
    import sweep_pkg::*;

    // byte lanes of a wide word, byte 0 being the most significant
    function automatic logic [47:0] putByte(input logic [47:0] w, input logic [2:0] idx, input logic [7:0] b);
        logic [47:0] r;
        r = w;
        for (int i = 0; i < 6; i++)
            if (idx == 3'(i))
                r[8*(5-i) +: 8] = b;
        return r;
    endfunction

    function automatic logic [7:0] getByte(input logic [47:0] w, input logic [2:0] idx);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 6; i++)
            if (idx == 3'(i))
                r = w[8*(5-i) +: 8];
        return r;
    endfunction

    function automatic logic inWindow(input logic [5:0] a, input logic [5:0] base, input logic [5:0] n);
        return (a >= base) && ((a - base) < n);
    endfunction

    logic [WORD_W-1:0] lowBuf_q, highBuf_q, stepBuf_q;
    logic [RATE_W-1:0] rateBuf_q;
    ctrl_t             ctrlBuf_q;
    logic [WORD_W-1:0] lowA_q, highA_q, stepA_q;
    logic [RATE_W-1:0] rateA_q;
    ctrl_t             ctrlA_q;
    logic [WORD_W-1:0] acc_q, acc_d, freq_q, freq_d, phase_q;
    logic              up_q, up_d;
    sweep_state_t      state_q, state_d;
    logic              updPrev_q, keyPrev_q, triPrev_q, clrPulse_q;
    logic [7:0]        rdData_q;

    // register decode
    wire        selLow    = inWindow(regReq.addr, `OFF_LOW_WORD, `WORD_BYTES);
    wire        selHigh   = inWindow(regReq.addr, `OFF_HIGH_WORD, `WORD_BYTES);
    wire        selStep   = inWindow(regReq.addr, `OFF_STEP_WORD, `WORD_BYTES);
    wire        selRate   = inWindow(regReq.addr, `OFF_RAMP_RATE, `RATE_BYTES);
    wire        selCtrl   = inWindow(regReq.addr, `OFF_CONTROL, `ONE_BYTE);
    wire        selStatus = inWindow(regReq.addr, `OFF_STATUS, `ONE_BYTE);
    wire  [2:0] idxLow    = 3'(regReq.addr - `OFF_LOW_WORD);
    wire  [2:0] idxHigh   = 3'(regReq.addr - `OFF_HIGH_WORD);
    wire  [2:0] idxStep   = 3'(regReq.addr - `OFF_STEP_WORD);
    wire  [2:0] idxRate   = 3'(regReq.addr - `OFF_RAMP_RATE);
    wire [47:0] rateWide  = {28'h000_0000, rateBuf_q};
    wire [47:0] rateNew   = putByte(rateWide, 3'(idxRate + 3'h3), regReq.data);
    wire  [7:0] ctrlByte  = {ctrlBuf_q.stepClear, ctrlBuf_q.fullClear, ctrlBuf_q.triangle,
                             1'b0, ctrlBuf_q.mode, 1'b0};
    wire  [7:0] statusByte = {5'h00, up_q, state_q == ST_DWELL, state_q == ST_RAMP};
    wire  [7:0] readByte  = selLow    ? getByte(lowBuf_q, idxLow)   :
                            selHigh   ? getByte(highBuf_q, idxHigh) :
                            selStep   ? getByte(stepBuf_q, idxStep) :
                            selRate   ? getByte(rateWide, 3'(idxRate + 3'h3)) :
                            selCtrl   ? ctrlByte   :
                            selStatus ? statusByte : `BYTE_ZERO;

    // buffer registers: writes are held here until an update edge; unmapped writes are dropped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowBuf_q  <= `WORD_RESET;
            highBuf_q <= `WORD_RESET;
            stepBuf_q <= `WORD_RESET;
            rateBuf_q <= `RATE_RESET;
            ctrlBuf_q <= '0;
            rdData_q  <= `BYTE_ZERO;
        end
        else
        begin
            if (regReq.wr && selLow)
                lowBuf_q <= putByte(lowBuf_q, idxLow, regReq.data);
            if (regReq.wr && selHigh)
                highBuf_q <= putByte(highBuf_q, idxHigh, regReq.data);
            if (regReq.wr && selStep)
                stepBuf_q <= putByte(stepBuf_q, idxStep, regReq.data);
            if (regReq.wr && selRate)
                rateBuf_q <= rateNew[RATE_W-1:0];
            if (regReq.wr && selCtrl)
                ctrlBuf_q <= {regReq.data[`CTRL_STEP_CLR_BIT], regReq.data[`CTRL_FULL_CLR_BIT],
                              regReq.data[`CTRL_TRIANGLE_BIT],
                              mode_t'(regReq.data[`CTRL_MODE_MSB:`CTRL_MODE_LSB])};
            if (regReq.rd)
                rdData_q <= readByte;
        end
    end

    // update edge moves buffers into the core; step and rate may change mid-ramp
    wire updEdge = updateClock && !updPrev_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowA_q  <= `WORD_RESET;
            highA_q <= `WORD_RESET;
            stepA_q <= `WORD_RESET;
            rateA_q <= `RATE_RESET;
            ctrlA_q <= '0;
        end
        else if (updEdge)
        begin
            lowA_q  <= lowBuf_q;
            highA_q <= highBuf_q;
            stepA_q <= stepBuf_q;
            rateA_q <= rateBuf_q;
            ctrlA_q <= ctrlBuf_q;
        end
    end

    // edge trackers and the one-cycle step clear, re-fired on every update edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            updPrev_q  <= 1'b0;
            keyPrev_q  <= 1'b0;
            triPrev_q  <= 1'b0;
            clrPulse_q <= 1'b0;
        end
        else
        begin
            updPrev_q  <= updateClock;
            keyPrev_q  <= keySelectInput;
            triPrev_q  <= ctrlA_q.triangle;
            clrPulse_q <= updEdge && ctrlBuf_q.stepClear;
        end
    end

    // sweep decode
    wire              ramped   = (ctrlA_q.mode == MODE_RAMPED);
    wire              chirp    = (ctrlA_q.mode == MODE_CHIRP);
    wire              fullClr  = ctrlA_q.fullClear;
    wire              triRise  = ramped && ctrlA_q.triangle && !triPrev_q;
    wire              keyEdge  = ramped && !ctrlA_q.triangle && (keySelectInput != keyPrev_q);
    wire [WORD_W-1:0] span     = highA_q - lowA_q;
    wire   [WORD_W:0] accSum   = {1'b0, acc_q} + {1'b0, stepA_q};
    wire              reachEnd = accSum >= {1'b0, span};
    wire [WORD_W-1:0] curFreq  = up_q ? lowA_q + acc_q : highA_q - acc_q;
    wire [WORD_W-1:0] rebase   = keySelectInput ? curFreq - lowA_q : highA_q - curFreq;
    wire              tmrRun   = (state_q == ST_RAMP) && !fullClr && (ramped || chirp);
    wire              tmrLoad  = triRise || keyEdge || clrPulse_q;
    logic             tick;

    ramp_rate_timer #(
        .RATE_W (RATE_W)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .enable  (tmrRun),
        .restart (tmrLoad),
        .rate    (rateA_q),
        .tick    (tick)
    );

    // sweep state: direction, distance travelled from the start point, running or dwelling
    always_comb
    begin
        acc_d   = acc_q;
        up_d    = up_q;
        state_d = state_q;
        if (fullClr)
            acc_d = '0;
        else if (chirp)
        begin
            state_d = ST_RAMP;
            if (clrPulse_q)
                acc_d = '0;
            else if (tick)
                acc_d = acc_q + stepA_q;
        end
        else if (!ramped)
        begin
            acc_d   = '0;
            state_d = ST_IDLE;
        end
        else if (triRise)
        begin
            up_d    = !keySelectInput;
            acc_d   = '0;
            state_d = ST_RAMP;
        end
        else if (keyEdge)
        begin
            up_d    = keySelectInput;
            acc_d   = rebase;
            state_d = ST_RAMP;
        end
        else if (clrPulse_q)
        begin
            acc_d   = '0;
            // before any key change the clear only zeroes; the timer still waits for the key
            state_d = (state_q == ST_IDLE) ? ST_IDLE : ST_RAMP;
        end
        else if (tick)
        begin
            case (state_q)
                ST_RAMP:
                begin
                    if (!reachEnd)
                        acc_d = accSum[WORD_W-1:0];
                    else if (ctrlA_q.triangle)
                    begin
                        up_d  = !up_q;
                        acc_d = '0;
                    end
                    else
                    begin
                        acc_d   = span;
                        state_d = ST_DWELL;
                    end
                end
                default:
                    state_d = state_q;
            endcase
        end
    end

    // frequency feeding the phase accumulator, chosen by mode
    always_comb
    begin
        case (ctrlA_q.mode)
            MODE_KEYING: freq_d = keySelectInput ? highA_q : lowA_q;
            MODE_RAMPED: freq_d = curFreq;
            MODE_CHIRP:  freq_d = lowA_q + acc_q;
            default:     freq_d = lowA_q;
        endcase
        if (fullClr)
            freq_d = '0;
    end

    // accumulators; full clear keeps the phase at zero for as long as the bit stays set
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q   <= `WORD_RESET;
            up_q    <= 1'b1;
            state_q <= ST_IDLE;
            freq_q  <= `WORD_RESET;
            phase_q <= `WORD_RESET;
        end
        else
        begin
            acc_q   <= acc_d;
            up_q    <= up_d;
            state_q <= state_d;
            freq_q  <= freq_d;
            phase_q <= fullClr ? `WORD_RESET : phase_q + freq_q;
        end
    end

    assign rdData        = rdData_q;
    assign tuningWord    = freq_q;
    assign phaseWord     = phase_q;
    assign sweeping      = (state_q == ST_RAMP);
    assign atDestination = (state_q == ST_DWELL);

    wire quiet = ramped && !fullClr && !triRise && !keyEdge && !clrPulse_q;

    sequence s_clear_shot;
        clrPulse_q ##1 !clrPulse_q;
    endsequence

    property p_clear_one_cycle;
        @(posedge sys_clk) disable iff (!rst_n)
        (updEdge && ctrlBuf_q.stepClear) |=> s_clear_shot;
    endproperty
    a_clear_one_cycle: assert property (p_clear_one_cycle) else $error("step clear pulse not one cycle");

    property p_clear_zeroes;
        @(posedge sys_clk) disable iff (!rst_n)
        (clrPulse_q && ramped && !fullClr && !triRise && !keyEdge && state_q != ST_IDLE)
            |=> (acc_q == '0) && (state_q == ST_RAMP);
    endproperty
    a_clear_zeroes: assert property (p_clear_zeroes) else $error("step clear did not restart from start point");

    property p_step_add;
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && quiet && state_q == ST_RAMP && !reachEnd) |=> (acc_q == $past(acc_q) + $past(stepA_q));
    endproperty
    a_step_add: assert property (p_step_add) else $error("step word not accumulated on tick");

    property p_clamp_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        (tick && quiet && reachEnd && !ctrlA_q.triangle) |=> (acc_q == $past(span)) && atDestination && !tick;
    endproperty
    a_clamp_stop: assert property (p_clamp_stop) else $error("destination not clamped and held");

    property p_dwell_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (atDestination && quiet && !updEdge) |=> atDestination && $stable(acc_q);
    endproperty
    a_dwell_hold: assert property (p_dwell_hold) else $error("dwell left without key change");

    property p_key_starts;
        @(posedge sys_clk) disable iff (!rst_n)
        (keyEdge && !fullClr) |=> sweeping && (up_q == $past(keySelectInput));
    endproperty
    a_key_starts: assert property (p_key_starts) else $error("key change did not start ramp toward key");

    property p_tri_start;
        @(posedge sys_clk) disable iff (!rst_n)
        (triRise && !fullClr) |=> (up_q != $past(keySelectInput)) && (acc_q == '0);
    endproperty
    a_tri_start: assert property (p_tri_start) else $error("triangle sweep started at wrong end");

    property p_full_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        fullClr |=> (tuningWord == '0) && (phaseWord == '0) && (acc_q == '0);
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("full clear did not zero accumulators");

    property p_ramp_feed;
        @(posedge sys_clk) disable iff (!rst_n)
        (ramped && !fullClr) |=> (tuningWord == $past(curFreq));
    endproperty
    a_ramp_feed: assert property (p_ramp_feed) else $error("ramped frequency not fed to phase path");

    property p_update_only;
        @(posedge sys_clk) disable iff (!rst_n)
        !updEdge |=> $stable(lowA_q) && $stable(stepA_q) && $stable(rateA_q) && $stable(ctrlA_q);
    endproperty
    a_update_only: assert property (p_update_only) else $error("core registers changed without update edge");

endmodule

// File: sweep_host_model.sv
// host model: drives the register port, the update clock and the key input
`timescale 1ns/10ps
`include "sweep_consts.svh"
module sweep_host_model (
    input  wire logic           sys_clk,
    output sweep_pkg::reg_req_t regReq,
    output logic                updateClock,
    output logic                keySelectInput,
    input  wire logic [7:0]     rdData
);
    import sweep_pkg::*;

    // idle port at time zero, key low
    initial
    begin
        regReq = '0;
        updateClock = 1'b0;
        keySelectInput = 1'b0;
    end

    // most significant byte first, one byte per cycle, changed only at rising edges
    task automatic putBytes(input logic [5:0] base, input int n, input logic [47:0] v);
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            regReq <= '{wr: 1'b1, rd: 1'b0, addr: base + 6'(i), data: v[8*(n-1-i) +: 8]};
        end
        @(posedge sys_clk);
        regReq <= '0;
    endtask

    task automatic writeByte(input logic [5:0] a, input logic [7:0] d);
        putBytes(a, 1, {40'h0000_0000_00, d});
    endtask

    // lowest frequency always goes to the low word
    task automatic writeTones(input logic [47:0] lo, input logic [47:0] hi);
        putBytes(`OFF_LOW_WORD, 6, (lo < hi) ? lo : hi);
        putBytes(`OFF_HIGH_WORD, 6, (lo < hi) ? hi : lo);
    endtask

    // sign bit forced clear: ramped keying only accepts positive steps
    task automatic writeStep(input logic [47:0] s);
        putBytes(`OFF_STEP_WORD, 6, {1'b0, s[46:0]});
    endtask

    // zero is outside the legal range, so it is raised to one
    task automatic writeRate(input logic [19:0] r);
        putBytes(`OFF_RAMP_RATE, 3, {28'h000_0000, (r == 20'h0_0000) ? 20'h0_0001 : r});
    endtask

    task automatic readByte(input logic [5:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge sys_clk);
        regReq <= '0;
        #1;
        d = rdData;
    endtask

    task automatic setControl(input logic sc, input logic fc, input logic tri_, input mode_t m);
        writeByte(`OFF_CONTROL, {sc, fc, tri_, 1'b0, m, 1'b0});
    endtask

    // one low-to-high step, then back low so the next one is seen
    task automatic pulseUpdate();
        @(posedge sys_clk);
        updateClock <= 1'b1;
        @(posedge sys_clk);
        updateClock <= 1'b0;
    endtask

    // step accumulator starts from zero: clear bit low, high, low
    task automatic clearStep(input mode_t m);
        setControl(1'b0, 1'b0, 1'b0, m);
        pulseUpdate();
        setControl(1'b1, 1'b0, 1'b0, m);
        pulseUpdate();
        setControl(1'b0, 1'b0, 1'b0, m);
        pulseUpdate();
    endtask

    task automatic setKey(input logic k);
        @(posedge sys_clk);
        keySelectInput <= k;
    endtask
endmodule

// File: tb_top.sv
// self-checking bench for the ramped sweep engine
`timescale 1ns/10ps
`include "sweep_consts.svh"
module tb_top;
    import sweep_pkg::*;

    localparam logic [47:0] LOW  = 48'h0000_0000_0064;
    localparam logic [47:0] HIGH = 48'h0000_0000_006e;
    localparam logic [47:0] STEP = 48'h0000_0000_0003;
    localparam logic [19:0] RATE = 20'h0_0002;

    logic        sys_clk;
    logic        rst_n;
    reg_req_t    regReq;
    logic [7:0]  rdData;
    logic        updateClock;
    logic        keySelectInput;
    logic [47:0] tuningWord;
    logic [47:0] phaseWord;
    logic        sweeping;
    logic        atDestination;
    int          fail_count = 0;
    int          cmp_count = 0;

    ramped_fsk_sweep_engine uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
        .updateClock(updateClock), .keySelectInput(keySelectInput), .tuningWord(tuningWord),
        .phaseWord(phaseWord), .sweeping(sweeping), .atDestination(atDestination));

    sweep_host_model h (
        .sys_clk(sys_clk), .regReq(regReq), .updateClock(updateClock),
        .keySelectInput(keySelectInput), .rdData(rdData));

    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // bounded wait for a frequency word; n returns the cycles spent
    task automatic waitFor(input logic [47:0] v, input int lim, output int n);
        #1;
        n = 0;
        while (tuningWord !== v && n < lim)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("tuningWord", v, tuningWord);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // reset values, read-only nibble, reserved bits, unmapped read
    task automatic testRegs();
        logic [7:0] d;
        h.readByte(6'h15, d);
        check("step byte reset", 48'h0, 48'(d));
        h.writeRate(20'hf_ffff);
        h.readByte(`OFF_RAMP_RATE, d);
        check("rate top byte", 48'h0000_0000_000f, 48'(d));
        h.writeByte(`OFF_CONTROL, 8'hff);
        h.readByte(`OFF_CONTROL, d);
        check("control reserved", 48'h0000_0000_00ee, 48'(d));
        h.readByte(6'h30, d);
        check("unmapped read", 48'h0, 48'(d));
        $display("test registers done");
    endtask

    // program a sweep; nothing moves until the key changes
    task automatic testSetup();
        int n;
        h.writeTones(LOW, HIGH);
        h.writeStep(STEP);
        h.writeRate(RATE);
        h.clearStep(MODE_RAMPED);
        repeat (10) @(posedge sys_clk);
        waitFor(LOW, 1, n);
        check("idle sweeping", 48'h0, 48'(sweeping));
        $display("test setup done");
    endtask

    // up ramp: spacing N+1, clamp at the high word, then dwell
    task automatic testRampUp();
        int         n;
        logic [7:0] d;
        h.setKey(1'b1);
        waitFor(LOW + STEP, 12, n);
        waitFor(LOW + 2 * STEP, 6, n);
        check("step spacing", 48'(RATE) + 48'h1, 48'(n));
        waitFor(LOW + 3 * STEP, 6, n);
        waitFor(HIGH, 6, n);
        check("clamp spacing", 48'(RATE) + 48'h1, 48'(n));
        repeat (20) @(posedge sys_clk);
        waitFor(HIGH, 0, n);
        check("dwell flag", 48'h1, 48'(atDestination));
        check("dwell sweeping", 48'h0, 48'(sweeping));
        h.readByte(`OFF_STATUS, d);
        check("status dwell", 48'h0000_0000_0006, 48'(d));
        $display("test ramp up done");
    endtask

    // early toggle reverses the ramp back to the high word
    task automatic testReverse();
        int n;
        h.setKey(1'b0);
        waitFor(HIGH - STEP, 12, n);
        h.setKey(1'b1);
        waitFor(HIGH, 20, n);
        $display("test reverse done");
    endtask

    // step clear restarts from the low word, again on each update while held
    task automatic testStepClear();
        int n;
        h.setControl(1'b1, 1'b0, 1'b0, MODE_RAMPED);
        h.pulseUpdate();
        waitFor(LOW, 8, n);
        waitFor(HIGH, 30, n);
        h.pulseUpdate();
        waitFor(LOW, 8, n);
        h.setControl(1'b0, 1'b0, 1'b0, MODE_RAMPED);
        h.pulseUpdate();
        waitFor(HIGH, 30, n);
        $display("test step clear done");
    endtask

    // full clear holds both accumulators at zero until released
    task automatic testFullClear();
        logic [47:0] p;
        int          n;
        h.setControl(1'b0, 1'b1, 1'b0, MODE_RAMPED);
        h.pulseUpdate();
        repeat (14) @(posedge sys_clk);
        waitFor(48'h0, 0, n);
        check("phase held", 48'h0, phaseWord);
        h.setControl(1'b0, 1'b0, 1'b0, MODE_RAMPED);
        h.pulseUpdate();
        repeat (6) @(posedge sys_clk);
        #1;
        p = phaseWord;
        @(posedge sys_clk);
        #1;
        check("phase resumes", p + LOW, phaseWord);
        $display("test full clear done");
    endtask

    // triangle with key high starts at the high word and keeps bouncing
    task automatic testTriangle();
        int n;
        h.setControl(1'b0, 1'b0, 1'b1, MODE_RAMPED);
        h.pulseUpdate();
        waitFor(HIGH, 8, n);
        waitFor(HIGH - STEP, 6, n);
        h.setKey(1'b0);
        waitFor(LOW, 40, n);
        waitFor(LOW + STEP, 8, n);
        waitFor(HIGH, 40, n);
        check("triangle running", 48'h1, 48'(sweeping));
        $display("test triangle done");
    endtask

    // other mode codes do not ramp; chirp runs past the high word
    task automatic testModes();
        mode_t ms[2];
        int    n;
        ms = '{MODE_SINGLE, MODE_PHASE_KEY};
        h.setControl(1'b0, 1'b0, 1'b0, MODE_KEYING);
        h.pulseUpdate();
        h.setKey(1'b1);
        waitFor(HIGH, 6, n);
        check("keying no sweep", 48'h0, 48'(sweeping));
        foreach (ms[i])
        begin
            h.setControl(1'b0, 1'b0, 1'b0, ms[i]);
            h.pulseUpdate();
            h.setKey(1'(i));
            repeat (6) @(posedge sys_clk);
            waitFor(LOW, 0, n);
        end
        h.setControl(1'b1, 1'b0, 1'b0, MODE_CHIRP);
        h.pulseUpdate();
        waitFor(LOW, 8, n);
        waitFor(HIGH + 2 * 48'h1, 40, n);
        $display("test modes done");
    endtask

    // reset, then the scenarios in order
    initial
    begin
        rst_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        testRegs();
        testSetup();
        testRampUp();
        testReverse();
        testStepClear();
        testFullClear();
        testTriangle();
        testModes();
        complete_run();
    end

    // hang guard, well beyond the roughly three hundred cycles the scenarios need
    initial
    begin
        repeat (8000) @(posedge sys_clk);
        fail_count++;
        $display("mismatch watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
